// ===== logic/sld_pkg.sv
package sld_pkg;
   // ===========================================================
   // Register offsets
   localparam logic [7:0] ADDR_STATE_CTRL = 8'h04;
   localparam logic [7:0] ADDR_DC_CTRL = 8'h09;
   localparam logic [7:0] ADDR_DC_RESULT = 8'h0c;
   localparam logic [7:0] ADDR_STATE_REPORT = 8'h0f;
   localparam logic [7:0] ADDR_AC_CTRL = 8'h15;
   localparam logic [7:0] ADDR_AC_LOOP = 8'h16;
   localparam logic [7:0] ADDR_AC_IMP = 8'h17;
   localparam logic [7:0] ADDR_PHASE_HI = 8'h1b;
   localparam logic [7:0] ADDR_PHASE_LO = 8'h1c;
   localparam logic [7:0] ADDR_STIM_HI = 8'h1d;
   localparam logic [7:0] ADDR_STIM_LO = 8'h1e;
   // ===========================================================
   // Field positions
   localparam int AC_EN_BIT = 3;
   localparam int AC_GAIN_BIT = 2;
   localparam int AC_CUR_BIT = 1;
   localparam int LOOP_BIT = 7;
   localparam int DC_BYPASS_BIT = 0;
   localparam int DC_MANUAL_BIT = 1;
   localparam int LINE_DET_BIT = 2;
   localparam int SL_THR_LSB = 4;
   localparam int SL_THR_W = 4;
   // ===========================================================
   // Reset values
   localparam logic [7:0] DC_CTRL_RST = 8'h00;
   localparam logic [7:0] AC_CTRL_RST = 8'h00;
   localparam logic [7:0] AC_LOOP_RST = 8'h00;
   localparam logic [1:0] CH_CMD_RST = 2'h0;
   // ===========================================================
   // Channel states
   typedef enum logic [2:0] {
      SLD_CH_HIZ = 3'h0,
      SLD_CH_MUTE = 3'h1,
      SLD_CH_PLAY = 3'h2,
      SLD_CH_DCDIAG = 3'h3,
      SLD_CH_ACDIAG = 3'h4,
      SLD_CH_RAMPDN = 3'h5
   } sld_ch_t;
   // ===========================================================
   // Commanded states in the state control register
   localparam logic [1:0] CMD_HIZ = 2'h0;
   localparam logic [1:0] CMD_MUTE = 2'h1;
   localparam logic [1:0] CMD_PLAY = 2'h2;
   // ===========================================================
   // Timing
   localparam int CLK_MHZ = 100;
   localparam int TEST_US = 10;
   localparam int TEST_CYC = TEST_US * CLK_MHZ;
   localparam int RAMP_US = 5;
   localparam int RAMP_CYC = RAMP_US * CLK_MHZ;
   localparam int CNT_W = 16;
   // Number of DC tests, line test index
   localparam int DC_TESTS = 4;
   localparam int LINE_IDX = 4;
endpackage

// ===== logic/sld_ramp.sv
`timescale 1ns/10ps
// ===========================================================
// Linear level ramp used for test tones and audio fades
module sld_ramp #(
   parameter int STEPS = 500
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic up,
   output logic [15:0] level,
   output logic at_top,
   output logic at_zero
);
   typedef struct packed {
      logic [15:0] lvl;
   } sld_ramp_st_t;
   sld_ramp_st_t s_r, s_nxt;
   localparam logic [15:0] STEP = 16'(16'hffff / STEPS);
   localparam logic [15:0] TOP = 16'(STEP * STEPS);

   always_comb begin
      s_nxt = s_r;
      if (up && s_r.lvl < TOP) begin
         s_nxt.lvl = s_r.lvl + STEP;
      end else if (!up && s_r.lvl != 16'h0000) begin
         s_nxt.lvl = s_r.lvl - STEP;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.lvl;
   assign at_top = (s_r.lvl == TOP);
   assign at_zero = (s_r.lvl == 16'h0000);
endmodule

// ===== logic/sld_top.sv
`timescale 1ns/10ps
module sld_top #(
   parameter int TEST_CYCLES = sld_pkg::TEST_CYC,
   parameter int RAMP_CYCLES = sld_pkg::RAMP_CYC,
   parameter int SL_W = sld_pkg::SL_THR_W
) (
   input wire logic core_clk,
   input wire logic rstn,
   // Host register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Analog sense comparators from the output bridge
   input wire logic sense_supply_short,
   input wire logic sense_ground_short,
   input wire logic sense_open,
   input wire logic [SL_W-1:0] sense_load_level,
   input wire logic sense_line_load,
   // AC measurement front end
   input wire logic [7:0] meas_impedance,
   input wire logic [15:0] meas_phase,
   input wire logic [15:0] meas_stimulus,
   // Bridge controls
   output logic bridge_drive,
   output logic bridge_loopback,
   output logic ac_gain_sel,
   output logic ac_current_sel,
   output logic [15:0] signal_level,
   output logic [4:0] diag_probe
);
   // ===========================================================
   // State
   typedef struct packed {
      sld_pkg::sld_ch_t ch;
      logic [1:0] cmd;
      logic [1:0] cmd_prev;
      logic [7:0] dc_ctrl;
      logic [7:0] ac_ctrl;
      logic [7:0] ac_loop;
      logic [4:0] dc_res;
      logic [2:0] test_idx;
      logic [sld_pkg::CNT_W-1:0] cnt;
      logic manual_pend;
      logic ac_done;
      logic ac_ramp_dn;
      logic [7:0] imp;
      logic [15:0] phase;
      logic [15:0] stim;
      logic [7:0] rdata;
      logic drive;
      logic loopback;
      logic tone_up;
      logic [4:0] probe;
   } sld_st_t;

   sld_st_t s_r, s_nxt;
   logic [15:0] ramp_level;
   logic ramp_top;
   logic ramp_zero;

   // ===========================================================
   // Shared decode
   function automatic logic is_active(input logic [1:0] c);
      is_active = (c == sld_pkg::CMD_MUTE) || (c == sld_pkg::CMD_PLAY);
   endfunction

   function automatic sld_pkg::sld_ch_t cmd_state(input logic [1:0] c);
      case (c)
         sld_pkg::CMD_MUTE: cmd_state = sld_pkg::SLD_CH_MUTE;
         sld_pkg::CMD_PLAY: cmd_state = sld_pkg::SLD_CH_PLAY;
         default: cmd_state = sld_pkg::SLD_CH_HIZ;
      endcase
   endfunction

   // ===========================================================
   // Ramp for tone and audio fades
   sld_ramp #(
      .STEPS(RAMP_CYCLES)
   ) u_ramp (
      .core_clk(core_clk),
      .rstn(rstn),
      .up(s_r.tone_up),
      .level(ramp_level),
      .at_top(ramp_top),
      .at_zero(ramp_zero)
   );

   // ===========================================================
   // Next state
   always_comb begin
      logic test_fail;
      logic [sld_pkg::CNT_W-1:0] tc;
      test_fail = 1'b0;
      tc = sld_pkg::CNT_W'(TEST_CYCLES);
      s_nxt = s_r;
      s_nxt.cmd_prev = s_r.cmd;
      s_nxt.probe = '0;

      // Register writes
      if (reg_wr) begin
         case (reg_addr)
            sld_pkg::ADDR_STATE_CTRL: s_nxt.cmd = reg_wdata[1:0];
            sld_pkg::ADDR_DC_CTRL: begin
               s_nxt.dc_ctrl = reg_wdata;
               if (reg_wdata[sld_pkg::DC_MANUAL_BIT]) begin
                  s_nxt.manual_pend = 1'b1;
               end
            end
            sld_pkg::ADDR_AC_CTRL: s_nxt.ac_ctrl = reg_wdata;
            sld_pkg::ADDR_AC_LOOP: s_nxt.ac_loop = reg_wdata;
            default: ;
         endcase
      end
      s_nxt.dc_ctrl[sld_pkg::DC_MANUAL_BIT] = 1'b0;

      // Register reads
      s_nxt.rdata = 8'h00;
      if (reg_rd) begin
         case (reg_addr)
            sld_pkg::ADDR_STATE_CTRL: s_nxt.rdata = {6'h00, s_r.cmd};
            sld_pkg::ADDR_DC_CTRL: s_nxt.rdata = s_r.dc_ctrl;
            sld_pkg::ADDR_DC_RESULT: s_nxt.rdata = {3'h0, s_r.dc_res};
            sld_pkg::ADDR_STATE_REPORT: s_nxt.rdata = {5'h00, s_r.ch};
            sld_pkg::ADDR_AC_CTRL: s_nxt.rdata = s_r.ac_ctrl;
            sld_pkg::ADDR_AC_LOOP: s_nxt.rdata = s_r.ac_loop;
            sld_pkg::ADDR_AC_IMP: s_nxt.rdata = s_r.imp;
            sld_pkg::ADDR_PHASE_HI: s_nxt.rdata = s_r.phase[15:8];
            sld_pkg::ADDR_PHASE_LO: s_nxt.rdata = s_r.phase[7:0];
            sld_pkg::ADDR_STIM_HI: s_nxt.rdata = s_r.stim[15:8];
            sld_pkg::ADDR_STIM_LO: s_nxt.rdata = s_r.stim[7:0];
            default: s_nxt.rdata = 8'h00;
         endcase
      end

      // Clearing the enable re-arms the AC diagnostic
      if (!s_r.ac_ctrl[sld_pkg::AC_EN_BIT]) begin
         s_nxt.ac_done = 1'b0;
      end

      if (s_r.cnt != '0) begin
         s_nxt.cnt = s_r.cnt - 1'b1;
      end

      // Channel sequencer
      case (s_r.ch)
         sld_pkg::SLD_CH_HIZ: begin
            s_nxt.drive = 1'b0;
            s_nxt.tone_up = 1'b0;
            if (s_nxt.manual_pend ||
                (is_active(s_r.cmd) && !s_r.dc_ctrl[sld_pkg::DC_BYPASS_BIT] &&
                 !is_active(s_r.cmd_prev))) begin
               s_nxt.ch = sld_pkg::SLD_CH_DCDIAG;
               s_nxt.manual_pend = 1'b0;
               s_nxt.test_idx = '0;
               s_nxt.dc_res = '0;
               s_nxt.cnt = tc;
            end else if (is_active(s_r.cmd) && !is_active(s_r.cmd_prev)) begin
               s_nxt.ch = cmd_state(s_r.cmd);
               s_nxt.drive = 1'b1;
            end else if (!is_active(s_r.cmd) && s_r.ac_ctrl[sld_pkg::AC_EN_BIT] &&
                         !s_r.ac_done) begin
               s_nxt.ch = sld_pkg::SLD_CH_ACDIAG;
               s_nxt.loopback = s_r.ac_loop[sld_pkg::LOOP_BIT];
               s_nxt.drive = 1'b1;
               s_nxt.tone_up = 1'b1;
               s_nxt.ac_ramp_dn = 1'b0;
               s_nxt.cnt = tc;
            end
         end
         sld_pkg::SLD_CH_MUTE, sld_pkg::SLD_CH_PLAY: begin
            s_nxt.tone_up = (s_r.ch == sld_pkg::SLD_CH_PLAY);
            if (s_nxt.manual_pend) begin
               s_nxt.ch = sld_pkg::SLD_CH_RAMPDN;
               s_nxt.tone_up = 1'b0;
            end else if (!is_active(s_r.cmd)) begin
               s_nxt.ch = sld_pkg::SLD_CH_RAMPDN;
               s_nxt.tone_up = 1'b0;
            end else begin
               s_nxt.ch = cmd_state(s_r.cmd);
               s_nxt.drive = 1'b1;
            end
         end
         sld_pkg::SLD_CH_RAMPDN: begin
            s_nxt.tone_up = 1'b0;
            if (ramp_zero) begin
               s_nxt.ch = sld_pkg::SLD_CH_HIZ;
               s_nxt.drive = 1'b0;
            end
         end
         sld_pkg::SLD_CH_DCDIAG: begin
            // Runs on core clock only, independent of audio clocks
            s_nxt.drive = 1'b0;
            s_nxt.probe = 5'(1) << s_r.test_idx;
            case (s_r.test_idx)
               3'h0: test_fail = sense_supply_short;
               3'h1: test_fail = sense_ground_short;
               3'h2: test_fail = sense_open;
               3'h3: test_fail = (sense_load_level <
                  s_r.dc_ctrl[sld_pkg::SL_THR_LSB +: SL_W]);
               3'h4: test_fail = sense_line_load;
               default: test_fail = 1'b0;
            endcase
            if (s_r.cnt == '0) begin
               s_nxt.dc_res[s_r.test_idx] = test_fail;
               s_nxt.cnt = tc;
               if (s_r.test_idx == 3'(sld_pkg::DC_TESTS - 1) &&
                   s_r.dc_res[2] && s_r.dc_ctrl[sld_pkg::LINE_DET_BIT]) begin
                  s_nxt.test_idx = 3'(sld_pkg::LINE_IDX);
               end else if (s_r.test_idx >= 3'(sld_pkg::DC_TESTS - 1)) begin
                  s_nxt.ch = sld_pkg::SLD_CH_HIZ;
                  s_nxt.cmd_prev = s_r.cmd;
                  s_nxt.test_idx = '0;
                  if (is_active(s_r.cmd) && !(s_nxt.dc_res[3:0] != '0)) begin
                     // Drive starts one cycle later, once the probe is idle
                     s_nxt.ch = cmd_state(s_r.cmd);
                  end
               end else begin
                  s_nxt.test_idx = s_r.test_idx + 1'b1;
               end
            end
         end
         sld_pkg::SLD_CH_ACDIAG: begin
            if (!s_r.ac_ramp_dn && ramp_top && s_r.cnt == '0) begin
               s_nxt.ac_ramp_dn = 1'b1;
               s_nxt.tone_up = 1'b0;
               s_nxt.imp = meas_impedance;
               s_nxt.phase = meas_phase;
               if (!s_r.loopback) begin
                  s_nxt.stim = meas_stimulus;
               end
            end else if (!s_r.ac_ctrl[sld_pkg::AC_EN_BIT] && !s_r.ac_ramp_dn) begin
               s_nxt.ac_ramp_dn = 1'b1;
               s_nxt.tone_up = 1'b0;
            end else if (s_r.ac_ramp_dn && ramp_zero) begin
               s_nxt.ch = sld_pkg::SLD_CH_HIZ;
               s_nxt.drive = 1'b0;
               s_nxt.loopback = 1'b0;
               s_nxt.ac_done = 1'b1;
            end
         end
         default: s_nxt.ch = sld_pkg::SLD_CH_HIZ;
      endcase
   end

   // ===========================================================
   // Registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_r <= '0;
         s_r.ch <= sld_pkg::SLD_CH_HIZ;
         s_r.cmd <= sld_pkg::CH_CMD_RST;
         s_r.cmd_prev <= sld_pkg::CH_CMD_RST;
         s_r.dc_ctrl <= sld_pkg::DC_CTRL_RST;
         s_r.ac_ctrl <= sld_pkg::AC_CTRL_RST;
         s_r.ac_loop <= sld_pkg::AC_LOOP_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ===========================================================
   // Outputs
   logic [15:0] level_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         level_r <= 16'h0000;
      end else begin
         level_r <= ramp_level;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign bridge_drive = s_r.drive;
   assign bridge_loopback = s_r.loopback;
   assign ac_gain_sel = s_r.ac_ctrl[sld_pkg::AC_GAIN_BIT];
   assign ac_current_sel = s_r.ac_ctrl[sld_pkg::AC_CUR_BIT];
   assign signal_level = level_r;
   assign diag_probe = s_r.probe;
endmodule

// ===== sim/sld_chk.sv
`timescale 1ns/10ps
// ===========================================================
// Port checker
module sld_chk #(
   parameter int TEST_CYCLES = 4
) (
   input wire logic core_clk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata,
   input wire logic bridge_drive,
   input wire logic bridge_loopback,
   input wire logic ac_gain_sel,
   input wire logic ac_current_sel,
   input wire logic [15:0] signal_level,
   input wire logic [4:0] diag_probe
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);
   // ===========================================================
   // Run length of each probe value
   logic [4:0] prev_r;
   logic [15:0] len_r;
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         prev_r <= 5'h00;
         len_r <= 16'h0000;
      end else begin
         prev_r <= diag_probe;
         len_r <= (diag_probe == prev_r) ? len_r + 16'h0001 : 16'h0001;
      end
   end
   // ===========================================================
   // Assertions
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero while idle");
   a_probe_hot: assert property ($onehot0(diag_probe))
      else $error("more than one test running");
   a_dc_quiet: assert property (diag_probe != 5'h00 |-> !bridge_drive)
      else $error("bridge drives during a dc test");
   a_ground_order: assert property ($rose(diag_probe[1]) |-> $past(diag_probe[0]))
      else $error("ground test not after supply test");
   a_line_order: assert property ($rose(diag_probe[4]) |-> $past(diag_probe[3]))
      else $error("line test not after the dc tests");
   a_test_len: assert property (prev_r != 5'h00 && diag_probe != prev_r
      |-> len_r == TEST_CYCLES + 1)
      else $error("dc test length wrong");
   a_gain_map: assert property (reg_wr && reg_addr == sld_pkg::ADDR_AC_CTRL
      |-> ##2 ac_gain_sel == $past(reg_wdata[sld_pkg::AC_GAIN_BIT], 2))
      else $error("gain select does not follow control");
   a_cur_map: assert property (reg_wr && reg_addr == sld_pkg::ADDR_AC_CTRL
      |-> ##2 ac_current_sel == $past(reg_wdata[sld_pkg::AC_CUR_BIT], 2))
      else $error("current select does not follow control");
   a_loop_drive: assert property (bridge_loopback |-> bridge_drive)
      else $error("loopback active outside ac run");
   a_ramp_base: assert property ($rose(bridge_drive) |-> signal_level == 16'h0000)
      else $error("level not zero at drive start");
endmodule

bind sld_top sld_chk #(.TEST_CYCLES(TEST_CYCLES)) sld_chk_inst (.core_clk(core_clk),
   .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .bridge_drive(bridge_drive),
   .bridge_loopback(bridge_loopback), .ac_gain_sel(ac_gain_sel),
   .ac_current_sel(ac_current_sel), .signal_level(signal_level), .diag_probe(diag_probe));

// ===== sim/sld_bridge.sv
`timescale 1ns/10ps
// ===========================================================
// Output bridge sense and AC front end
module sld_bridge (
   input wire logic bridge_drive,
   input wire logic [4:0] faults,
   input wire logic [3:0] load_lvl,
   input wire logic [7:0] imp,
   input wire logic [15:0] ph,
   input wire logic [15:0] stim,
   output logic sense_supply_short,
   output logic sense_ground_short,
   output logic sense_open,
   output logic [3:0] sense_load_level,
   output logic sense_line_load,
   output logic [7:0] meas_impedance,
   output logic [15:0] meas_phase,
   output logic [15:0] meas_stimulus
);
   assign sense_supply_short = faults[0];
   assign sense_ground_short = faults[1];
   assign sense_open = faults[2];
   assign sense_load_level = load_lvl;
   assign sense_line_load = faults[4];
   // Results are junk unless the bridge drives the tone
   assign meas_impedance = bridge_drive ? imp : ~imp;
   assign meas_phase = bridge_drive ? ph : ~ph;
   assign meas_stimulus = bridge_drive ? stim : ~stim;
endmodule

// ===== sim/tb.sv
`timescale 1ns/10ps
module tb;
   logic core_clk = 1'b0;
   logic rstn = 1'b0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic [4:0] faults = 5'h00;
   logic [3:0] load_lvl = 4'hf;
   logic [7:0] imp = 8'h00;
   logic [15:0] ph = 16'h0000;
   logic [15:0] stim = 16'h0000;
   logic [7:0] reg_rdata;
   logic s_sup, s_gnd, s_open, s_line, bridge_drive, bridge_loopback, gain, cur;
   logic [3:0] s_lvl;
   logic [7:0] m_imp;
   logic [15:0] m_ph, m_stim, signal_level;
   logic [4:0] diag_probe;
   int bad_count = 0;
   int n_checks = 0;
   always #5 core_clk = ~core_clk;
   sld_top #(.TEST_CYCLES(4), .RAMP_CYCLES(4)) sld_top_inst (.core_clk(core_clk), .rstn(rstn),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .sense_supply_short(s_sup), .sense_ground_short(s_gnd),
      .sense_open(s_open), .sense_load_level(s_lvl), .sense_line_load(s_line),
      .meas_impedance(m_imp), .meas_phase(m_ph), .meas_stimulus(m_stim),
      .bridge_drive(bridge_drive), .bridge_loopback(bridge_loopback), .ac_gain_sel(gain),
      .ac_current_sel(cur), .signal_level(signal_level), .diag_probe(diag_probe));
   sld_bridge sld_bridge_inst (.bridge_drive(bridge_drive), .faults(faults),
      .load_lvl(load_lvl), .imp(imp), .ph(ph), .stim(stim), .sense_supply_short(s_sup),
      .sense_ground_short(s_gnd), .sense_open(s_open), .sense_load_level(s_lvl),
      .sense_line_load(s_line), .meas_impedance(m_imp), .meas_phase(m_ph),
      .meas_stimulus(m_stim));
   // ===========================================================
   // Shared tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 chk({8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic setf(input logic [4:0] f, input logic [3:0] l);
      @(posedge core_clk);
      faults <= f;
      load_lvl <= l;
   endtask
   task automatic wait_drv(input logic lv);
      for (int i = 0; i < 300 && bridge_drive !== lv; i++) @(posedge core_clk);
   endtask
   task automatic wait_dc();
      for (int i = 0; i < 300 && diag_probe === 5'h00; i++) @(posedge core_clk);
      for (int i = 0; i < 300 && diag_probe !== 5'h00; i++) @(posedge core_clk);
      repeat (4) @(posedge core_clk);
   endtask
   // ===========================================================
   // Scenarios
   task automatic t_reset();
      chk({bridge_drive, bridge_loopback, diag_probe}, 16'h0000);
      rchk(sld_pkg::ADDR_DC_CTRL, sld_pkg::DC_CTRL_RST);
      rchk(sld_pkg::ADDR_AC_CTRL, sld_pkg::AC_CTRL_RST);
      rchk(sld_pkg::ADDR_AC_LOOP, sld_pkg::AC_LOOP_RST);
      wr(sld_pkg::ADDR_AC_IMP, 8'hff);
      rchk(sld_pkg::ADDR_AC_IMP, 8'h00);
      rchk(8'h30, 8'h00);
   endtask
   task automatic t_dc_auto();
      wr(sld_pkg::ADDR_STATE_CTRL, {6'h00, sld_pkg::CMD_PLAY});
      repeat (2) @(posedge core_clk);
      #1 chk(diag_probe, 5'h01);
      wait_drv(1'b1);
      rchk(sld_pkg::ADDR_DC_RESULT, 8'h00);
      rchk(sld_pkg::ADDR_STATE_REPORT, 8'h02);
   endtask
   task automatic t_dc_manual();
      setf(5'h15, 4'hf);
      wr(sld_pkg::ADDR_DC_CTRL, 8'h06);
      wait_dc();
      rchk(sld_pkg::ADDR_DC_RESULT, 8'h15);
      rchk(sld_pkg::ADDR_STATE_REPORT, 8'h00);
      chk(bridge_drive, 1'b0);
   endtask
   task automatic t_short();
      for (int k = 0; k < 2; k++) begin
         setf(k ? 5'h00 : 5'h16, 4'h3);
         wr(sld_pkg::ADDR_DC_CTRL, k ? 8'h22 : 8'h82);
         wait_dc();
         rchk(sld_pkg::ADDR_DC_RESULT, k ? 8'h00 : 8'h0e);
      end
   endtask
   task automatic t_bypass();
      wr(sld_pkg::ADDR_STATE_CTRL, {6'h00, sld_pkg::CMD_HIZ});
      wait_drv(1'b0);
      wr(sld_pkg::ADDR_DC_CTRL, 8'h01);
      wr(sld_pkg::ADDR_STATE_CTRL, {6'h00, sld_pkg::CMD_MUTE});
      repeat (3) @(posedge core_clk);
      #1 chk({bridge_drive, diag_probe}, 16'h0020);
      rchk(sld_pkg::ADDR_STATE_REPORT, 8'h01);
      wr(sld_pkg::ADDR_STATE_CTRL, {6'h00, sld_pkg::CMD_HIZ});
      wr(sld_pkg::ADDR_DC_CTRL, 8'h00);
      wait_drv(1'b0);
   endtask
   task automatic t_ac();
      logic [15:0] pk;
      for (int lp = 1; lp >= 0; lp--) begin
         @(posedge core_clk);
         imp <= 8'h40 + 8'(lp);
         ph <= 16'h1200 + 16'(lp);
         stim <= 16'h08a0 + 16'(lp);
         wr(sld_pkg::ADDR_AC_LOOP, lp ? 8'h80 : 8'h00);
         wr(sld_pkg::ADDR_AC_CTRL, lp ? 8'h0e : 8'h08);
         wait_drv(1'b1);
         #1 chk({gain, cur, bridge_loopback}, lp ? 16'h0007 : 16'h0000);
         pk = 16'h0000;
         for (int i = 0; i < 300 && bridge_drive === 1'b1; i++) begin
            @(posedge core_clk);
            if (signal_level > pk) pk = signal_level;
         end
         chk(pk != 16'h0000, 1'b1);
         rchk(sld_pkg::ADDR_STATE_REPORT, 8'h00);
         rchk(sld_pkg::ADDR_AC_IMP, 8'h40 + 8'(lp));
         rchk(sld_pkg::ADDR_PHASE_HI, 8'h12);
         rchk(sld_pkg::ADDR_PHASE_LO, 8'(lp));
         rchk(sld_pkg::ADDR_STIM_HI, lp ? 8'h00 : 8'h08);
         rchk(sld_pkg::ADDR_STIM_LO, lp ? 8'h00 : 8'ha0);
         chk(signal_level, 16'h0000);
         repeat (10) @(posedge core_clk);
         #1 chk(bridge_drive, 1'b0);
         wr(sld_pkg::ADDR_AC_CTRL, 8'h00);
      end
   endtask
   task automatic wrap_up();
      if (bad_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ===========================================================
   // Main sequence and watchdog
   initial begin
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      t_reset();
      t_dc_auto();
      t_dc_manual();
      t_short();
      t_bypass();
      t_ac();
      wrap_up();
   end
   initial begin
      #200000;
      bad_count++;
      wrap_up();
   end
endmodule
